// >>> rtl/dual_timer_counter.sv
/*
 * Two timer/counters with four modes each, their control and mode
 * registers, the external interrupt flags, and an AHB-Lite slave.
 * Assumes ref_clk is the machine-cycle clock, all pins synchronous
 * to it, and a single AHB-Lite master doing whole-word transfers.
 */
// The AHB-Lite register port was decided locally.
// Function
// - timer function adds one every machine cycle.
// - counter function counts a high sample followed by a low sample.
// - counted value appears the cycle after the detecting cycle.
// - counting needs run bit and either gate clear or irq pin high.
// - source select clear counts cycles, set counts the pin.
// - mode 0 is 13 bits: high byte plus low five low-byte bits.
// - rollover from all ones to zero sets the overflow flag.
// - setting a run bit keeps the count registers.
// - mode 1 cascades both bytes into a 16-bit counter.
// - mode 2 low byte reloads from high byte on overflow.
// - timer 1 in mode 3 holds its count as if stopped.
// - timer 0 mode 3 splits into low counter and high timer.
// - timer 1 starts and stops via its own mode 3 then; here it also needs its run bit set.
// - overflow flags set on overflow, cleared on vectoring.
// - run bits are software writable and start or stop timers.
// - irq type bit selects falling edge or low level.
// - edge flags set on pin edge, cleared when processed.
// - mode register: timer 1 upper nibble, timer 0 lower.
// - each timer has high and low byte count registers.
module dual_timer_counter
(
    input wire logic ref_clk, // machine-cycle clock
    input wire logic rst_n, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic hready, // bus ready in
    input wire logic [31:0] hwdata, // write data
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic ext_count_in_0, // count pin, timer 0
    input wire logic ext_count_in_1, // count pin, timer 1
    input wire logic ext_irq_pin_0, // gate / irq pin 0
    input wire logic ext_irq_pin_1, // gate / irq pin 1
    input wire logic ack_overflow_0, // vectoring to timer 0 irq
    input wire logic ack_overflow_1, // vectoring to timer 1 irq
    input wire logic ack_edge_0, // vectoring to ext irq 0
    input wire logic ack_edge_1, // vectoring to ext irq 1
    output logic overflow_flag_0, // timer 0 irq request
    output logic overflow_flag_1, // timer 1 irq request
    output logic irq_edge_flag_0, // ext irq 0 request
    output logic irq_edge_flag_1, // ext irq 1 request
    output logic baud_tick // timer 1 overflow pulse
);
    import timer_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] timer_mode;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [1:0] cnt_smp;
    logic [1:0] cnt_prev;
    logic [1:0] irq_smp;
    logic [1:0] irq_prev;
    bus_state_t bus_state;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic [8:0] decode_addr(input logic [31:0] a);
        logic ok;
        ok = (a[31:IDX_MSB+1] == '0) && (a[IDX_LSB-1:0] == 2'h0);
        return {ok, a[IDX_MSB:IDX_LSB]};
    endfunction

    wire addr_taken = hsel & hready & htrans[1];
    wire [8:0] addr_dec = decode_addr(haddr);
    wire [7:0] wdat = hwdata[7:0];
    wire wr_go = clk_en & wr_pend;
    wire wr_ctrl = wr_go & (wr_idx == IDX_CONTROL);
    wire wr_mode = wr_go & (wr_idx == IDX_MODE);
    wire wr_tl0 = wr_go & (wr_idx == IDX_TL0);
    wire wr_th0 = wr_go & (wr_idx == IDX_TH0);
    wire wr_tl1 = wr_go & (wr_idx == IDX_TL1);
    wire wr_th1 = wr_go & (wr_idx == IDX_TH1);

    // unmapped addresses read as zero and ignore writes
    wire [7:0] rd_val =
        (rd_idx == IDX_CONTROL) ? ctrl :
        (rd_idx == IDX_MODE) ? timer_mode :
        (rd_idx == IDX_TL0) ? tl0 :
        (rd_idx == IDX_TH0) ? th0 :
        (rd_idx == IDX_TL1) ? tl1 :
        (rd_idx == IDX_TH1) ? th1 : 8'h00;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // a read costs one wait state so that a write just before it is
    // already committed when the value is captured
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_state <= BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata <= RDATA_RST;
            hresp <= HRESP_OKAY;
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
            rd_idx <= 8'h00;
        end
        else if (clk_en)
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    wr_pend <= addr_taken & hwrite & addr_dec[8];
                    wr_idx <= addr_dec[7:0];
                    rd_idx <= addr_dec[8] ? addr_dec[7:0] : 8'h00;
                    if (addr_taken & ~hwrite)
                    begin
                        bus_state <= BUS_READ;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_READ:
                begin
                    wr_pend <= 1'b0;
                    hrdata <= {24'h000000, rd_val};
                    hreadyout <= 1'b1;
                    bus_state <= BUS_IDLE;
                end
                default:
                begin
                    wr_pend <= 1'b0;
                    hreadyout <= 1'b1;
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    wire [1:0] count_pin = {ext_count_in_1, ext_count_in_0};
    wire [1:0] irq_pin = {ext_irq_pin_1, ext_irq_pin_0};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sample
            // one sample per machine cycle; a level shorter than a
            // cycle may be missed by design
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cnt_smp[gi] <= 1'b0;
                    cnt_prev[gi] <= 1'b0;
                    irq_smp[gi] <= 1'b1;
                    irq_prev[gi] <= 1'b1;
                end
                else if (clk_en)
                begin
                    cnt_smp[gi] <= count_pin[gi];
                    cnt_prev[gi] <= cnt_smp[gi];
                    irq_smp[gi] <= irq_pin[gi];
                    irq_prev[gi] <= irq_smp[gi];
                end
            end
        end
    endgenerate

    // high sample then low sample
    wire [1:0] cnt_fall = cnt_prev & ~cnt_smp;
    wire [1:0] irq_fall = irq_prev & ~irq_smp;

    // ------------------------------------------------------------
    // count engine
    // ------------------------------------------------------------
    function automatic count_step_t count_step(input timer_mode_t m,
        input logic [7:0] hi, input logic [7:0] lo, input logic en);
        count_step_t r;
        logic [12:0] v13;
        logic [15:0] v16;
        r.ovf = 1'b0;
        r.hi = hi;
        r.lo = lo;
        v13 = {hi, lo[PRESCALE_BITS-1:0]} + 13'h0001;
        v16 = {hi, lo} + 16'h0001;
        if (en)
        begin
            case (m)
                MODE_13BIT:
                begin
                    // upper low-byte bits are left alone
                    r.lo = {lo[7:PRESCALE_BITS], v13[PRESCALE_BITS-1:0]};
                    r.hi = v13[12:PRESCALE_BITS];
                    r.ovf = &{hi, lo[PRESCALE_BITS-1:0]};
                end
                MODE_16BIT:
                begin
                    r.hi = v16[15:8];
                    r.lo = v16[7:0];
                    r.ovf = &{hi, lo};
                end
                MODE_RELOAD:
                begin
                    r.lo = (&lo) ? hi : lo + 8'h01;
                    r.ovf = &lo;
                end
                default:
                begin
                    r.lo = lo + 8'h01;
                    r.ovf = &lo;
                end
            endcase
        end
        return r;
    endfunction

    wire timer_cfg_t cfg0 = timer_mode[3:0];
    wire timer_cfg_t cfg1 = timer_mode[7:4];
    wire split0 = (cfg0.mode == MODE_SPLIT);

    wire [1:0] tick = {cfg1.ext_src ? cnt_fall[1] : 1'b1,
                       cfg0.ext_src ? cnt_fall[0] : 1'b1};
    wire run0 = ctrl[BIT_TR0] & (~cfg0.gate | ext_irq_pin_0);
    // mode 3 on timer 1 acts like a cleared run bit
    wire run1 = ctrl[BIT_TR1] & (~cfg1.gate | ext_irq_pin_1)
        & (cfg1.mode != MODE_SPLIT);

    wire count_step_t step0 = count_step(cfg0.mode, th0, tl0,
        run0 & tick[0]);
    wire count_step_t step1 = count_step(cfg1.mode, th1, tl1,
        run1 & tick[1]);

    // split high byte: machine cycles only, borrows timer 1 run bit
    wire th0_run = split0 & ctrl[BIT_TR1];
    wire th0_ovf = th0_run & (&th0);
    wire [7:0] next_th0 = split0 ? (th0_run ? th0 + 8'h01 : th0)
        : step0.hi;

    // timer 1 keeps feeding the baud tick but loses its flag
    wire tf0_set = step0.ovf;
    wire tf1_set = split0 ? th0_ovf : step1.ovf;

    // ------------------------------------------------------------
    // control register update
    // ------------------------------------------------------------
    wire [7:0] ctrl_base = wr_ctrl ? wdat : ctrl;
    wire [1:0] edge_set = irq_fall & {ctrl[BIT_IT1], ctrl[BIT_IT0]};

    // hardware set beats a same-cycle clear from software or ack
    wire next_tf0 = (ctrl_base[BIT_TF0] & ~ack_overflow_0)
        | tf0_set;
    wire next_tf1 = (ctrl_base[BIT_TF1] & ~ack_overflow_1)
        | tf1_set;
    // level type: flag mirrors the low pin, ack has no lasting effect
    wire next_ie0 = ctrl[BIT_IT0] ?
        ((ctrl_base[BIT_IE0] & ~ack_edge_0) | edge_set[0]) :
        ~irq_smp[0];
    wire next_ie1 = ctrl[BIT_IT1] ?
        ((ctrl_base[BIT_IE1] & ~ack_edge_1) | edge_set[1]) :
        ~irq_smp[1];

    wire [7:0] next_ctrl = {next_tf1, ctrl_base[BIT_TR1], next_tf0,
        ctrl_base[BIT_TR0], next_ie1, ctrl_base[BIT_IT1], next_ie0,
        ctrl_base[BIT_IT0]};

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= CONTROL_RST;
            timer_mode <= MODE_RST;
            baud_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl <= next_ctrl;
            timer_mode <= wr_mode ? wdat : timer_mode;
            baud_tick <= step1.ovf;
        end
    end

    // writes take priority; a run-bit write touches no count byte
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tl0 <= COUNT_RST;
            th0 <= COUNT_RST;
            tl1 <= COUNT_RST;
            th1 <= COUNT_RST;
        end
        else if (clk_en)
        begin
            tl0 <= wr_tl0 ? wdat : step0.lo;
            th0 <= wr_th0 ? wdat : next_th0;
            tl1 <= wr_tl1 ? wdat : step1.lo;
            th1 <= wr_th1 ? wdat : step1.hi;
        end
    end

    assign overflow_flag_0 = ctrl[BIT_TF0];
    assign overflow_flag_1 = ctrl[BIT_TF1];
    assign irq_edge_flag_0 = ctrl[BIT_IE0];
    assign irq_edge_flag_1 = ctrl[BIT_IE1];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    wire no_cnt_wr0 = ~wr_tl0 & ~wr_th0;
    wire no_cnt_wr1 = ~wr_tl1 & ~wr_th1;
    wire no_ack = ~ack_overflow_0 & ~ack_overflow_1;

    sequence rd_taken;
        clk_en && bus_state == BUS_IDLE && addr_taken && !hwrite;
    endsequence

    sequence rd_answer;
        !hreadyout ##1 (clk_en ? hreadyout : !hreadyout);
    endsequence

    sequence fall_seen0;
        clk_en && cfg0.ext_src && run0 && cnt_fall[0]
            && cfg0.mode == MODE_16BIT && no_cnt_wr0;
    endsequence

    a_timer_rate_cycle: assert property (
        clk_en && !cfg0.ext_src && run0 && cfg0.mode == MODE_16BIT
            && no_cnt_wr0
        |=> {th0, tl0} == 16'($past({th0, tl0}) + 16'h0001))
        else $error("timer 0 did not advance one per cycle");

    a_count_edge_seen: assert property (
        fall_seen0 |=> tl0 == 8'($past(tl0) + 8'h01))
        else $error("falling count edge not counted next cycle");

    a_count_no_edge: assert property (
        clk_en && cfg0.ext_src && !cnt_fall[0]
            && cfg0.mode == MODE_16BIT && no_cnt_wr0
        |=> $stable({th0, tl0}))
        else $error("counter moved without a falling edge");

    a_gate_blocks_count: assert property (
        clk_en && cfg0.gate && !ext_irq_pin_0 && !split0 && no_cnt_wr0
        |=> $stable({th0, tl0}))
        else $error("gated timer 0 counted with pin low");

    a_mode0_rollover: assert property (
        clk_en && cfg0.mode == MODE_13BIT && run0 && tick[0]
            && th0 == 8'hFF && tl0[4:0] == 5'h1F && no_cnt_wr0
        |=> overflow_flag_0 && th0 == 8'h00 && tl0[4:0] == 5'h00
            && tl0[7:5] == $past(tl0[7:5]))
        else $error("13-bit rollover wrong");

    a_reload_low_byte: assert property (
        clk_en && cfg1.mode == MODE_RELOAD && run1 && tick[1]
            && tl1 == 8'hFF && no_cnt_wr1 && !split0
        |=> tl1 == $past(th1) && th1 == $past(th1) && overflow_flag_1)
        else $error("auto-reload did not reload or flag");

    a_t1_split_hold: assert property (
        clk_en && cfg1.mode == MODE_SPLIT && no_cnt_wr1
        |=> $stable({th1, tl1}))
        else $error("timer 1 in mode 3 changed count");

    a_split_high_byte: assert property (
        clk_en && split0 && ctrl[BIT_TR1] && th0 == 8'hFF
            && !wr_th0 && no_ack
        |=> th0 == 8'h00 && overflow_flag_1)
        else $error("split high byte overflow missed");

    a_flag_set_wins: assert property (
        clk_en && tf0_set && ack_overflow_0 |=> overflow_flag_0)
        else $error("overflow lost against clear");

    a_edge_flag_set: assert property (
        clk_en && ctrl[BIT_IT0] && irq_fall[0] |=> irq_edge_flag_0)
        else $error("falling irq edge not flagged");

    a_run_keeps_count: assert property (
        clk_en && wr_ctrl && !ctrl[BIT_TR0] && no_cnt_wr0 && !split0
        |=> $stable({th0, tl0}))
        else $error("run bit write altered count");

    a_write_wins_inc: assert property (
        clk_en && wr_tl0 |=> tl0 == $past(hwdata[7:0]))
        else $error("count write lost to increment");

    a_read_wait_state: assert property (
        rd_taken |=> rd_answer)
        else $error("read answer timing wrong");

endmodule

// >>> rtl/timer_pkg.sv
/*
 * Shared constants and types for the dual 8/16-bit timer/counter block.
 * Assumes a register bus that addresses registers by word index.
 */
package timer_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_TL0 = 8'h8A;
    localparam logic [7:0] IDX_TL1 = 8'h8B;
    localparam logic [7:0] IDX_TH0 = 8'h8C;
    localparam logic [7:0] IDX_TH1 = 8'h8D;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;

    // ------------------------------------------------------------
    // timer_control bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_IT0 = 0;
    localparam int unsigned BIT_IE0 = 1;
    localparam int unsigned BIT_IT1 = 2;
    localparam int unsigned BIT_IE1 = 3;
    localparam int unsigned BIT_TR0 = 4;
    localparam int unsigned BIT_TF0 = 5;
    localparam int unsigned BIT_TR1 = 6;
    localparam int unsigned BIT_TF1 = 7;

    // ------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h00000000;
    localparam int unsigned PRESCALE_BITS = 5;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_t;

    // one nibble of timer_mode: gate at 3, source select at 2
    typedef struct packed {
        logic gate;
        logic ext_src;
        timer_mode_t mode;
    } timer_cfg_t;

    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } count_step_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_READ = 2'b10
    } bus_state_t;

endpackage

// >>> sim/pin_model.sv
/*
 * Model of one timer's external count pin and gate/irq pin.
 * Assumes the bench strobes fall_req for one cycle, at most once
 * every five cycles, and sets gate_lvl by non-blocking assignment.
 */
module pin_model
(
    input wire logic ref_clk, // machine-cycle clock
    input wire logic rst_n, // async reset, active low
    input wire logic fall_req, // request one low pulse
    input wire logic gate_lvl, // wanted gate pin level
    output logic count_pin, // to the count input
    output logic gate_pin // to the gate / irq pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // pulse shaper
    // ------------------------------------------------------------
    logic [2:0] phase;

    // two cycles low, then at least three high: no level is missed
    assign count_pin = (phase < 3'h3);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= 3'h0;
            gate_pin <= 1'b1;
        end
        else
        begin
            gate_pin <= gate_lvl;
            if (phase != 3'h0)
                phase <= phase - 3'h1;
            else if (fall_req)
                phase <= 3'h4;
        end
    end
endmodule

// >>> sim/dual_timer_counter_tb_top.sv
/*
 * Self-checking bench for the dual timer/counter.
 * Assumes one AHB-Lite master (this bench) with hready fed back from
 * hreadyout, and pin_model instances on the count and gate pins.
 */
module dual_timer_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import timer_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [1:0] ack_ovf = 2'h0;
    logic [1:0] ack_edge = 2'h0;
    logic [1:0] req = 2'h0;
    logic [1:0] glvl = 2'h3;
    logic [1:0] cpin;
    logic [1:0] gpin;
    logic overflow_flag_0;
    logic overflow_flag_1;
    logic irq_edge_flag_0;
    logic irq_edge_flag_1;
    logic baud;
    logic [7:0] ticks = 8'h00;
    int error_cnt = 0;
    int tests_run = 0;

    always #50 ref_clk = ~ref_clk;

    // baud pulses are counted where they are settled
    always @(negedge ref_clk)
        if (baud === 1'b1)
            ticks <= ticks + 8'h01;

    dual_timer_counter dual_timer_counter_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .ext_count_in_0(cpin[0]), .ext_count_in_1(cpin[1]),
        .ext_irq_pin_0(gpin[0]), .ext_irq_pin_1(gpin[1]),
        .ack_overflow_0(ack_ovf[0]), .ack_overflow_1(ack_ovf[1]),
        .ack_edge_0(ack_edge[0]), .ack_edge_1(ack_edge[1]),
        .overflow_flag_0(overflow_flag_0),
        .overflow_flag_1(overflow_flag_1),
        .irq_edge_flag_0(irq_edge_flag_0),
        .irq_edge_flag_1(irq_edge_flag_1), .baud_tick(baud));

    for (genvar g = 0; g < 2; g++)
    begin : pins
        pin_model pin_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
            .fall_req(req[g]), .gate_lvl(glvl[g]), .count_pin(cpin[g]),
            .gate_pin(gpin[g]));
    end

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask

    // hready and hrdata are taken as they stand before the edge
    task automatic wait_rdy(output logic [31:0] rd);
        logic ok;
        for (int n = 0; n < 20; n++)
        begin
            @(negedge ref_clk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge ref_clk);
            if (ok === 1'b1)
                return;
        end
        error_cnt++;
        $display("unexpected at %0t: bus never ready", $time);
        finish_test();
    endtask

    task automatic xfer(input logic wr_en, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] rd);
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr_en;
        htrans <= 2'b10;
        wait_rdy(rd);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        xfer(1'b1, idx, v, d);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
        input logic [7:0] mask);
        logic [31:0] d;
        xfer(1'b0, idx, 8'h00, d);
        chk(d & {24'hFFFFFF, mask}, {24'h0, exp & mask});
    endtask

    function automatic logic eflag(input int t);
        return t ? irq_edge_flag_1 : irq_edge_flag_0;
    endfunction

    task automatic wait_flag(input int t, input logic v, output logic s);
        for (int n = 0; n < 10; n++)
        begin
            @(negedge ref_clk);
            s = eflag(t);
            if (s === v)
                break;
        end
        @(posedge ref_clk);
    endtask

    task automatic pulse(input int t);
        req[t] <= 1'b1;
        @(posedge ref_clk);
        req[t] <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask

    // five counts: two before the flag check, three after
    task automatic run_case(input int t, input logic [3:0] m,
        input logic [7:0] tl, th, mask, tl_exp, th_exp, input logic ovf);
        logic [7:0] lo_idx;
        logic [7:0] hi_idx;
        lo_idx = t ? IDX_TL1 : IDX_TL0;
        hi_idx = t ? IDX_TH1 : IDX_TH0;
        wr(IDX_MODE, t ? {m, 4'h0} : {4'h0, m});
        wr(lo_idx, tl);
        wr(hi_idx, th);
        wr(IDX_CONTROL, 8'h10 << (2 * t));
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(t ? overflow_flag_1 : overflow_flag_0, ovf);
        @(posedge ref_clk);
        wr(IDX_CONTROL, {ovf, 7'h0} >> (2 - 2 * t));
        rd_chk(lo_idx, tl_exp, mask);
        rd_chk(hi_idx, th_exp, 8'hFF);
        if (ovf)
        begin
            ack_ovf[t] <= 1'b1;
            @(posedge ref_clk);
            ack_ovf[t] <= 1'b0;
            @(negedge ref_clk);
            chk(t ? overflow_flag_1 : overflow_flag_0, 1'b0);
            @(posedge ref_clk);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic s;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(IDX_CONTROL + 8'(i), COUNT_RST, 8'hFF);
        chk(hresp, HRESP_OKAY);
        wr(8'h8E, 8'hAA);
        rd_chk(8'h8E, 8'h00, 8'hFF);
        $display("test registers done");
        for (int t = 0; t < 2; t++)
        begin
            run_case(t, 4'h0, 8'hFF, 8'hFF, 8'h1F, 8'h04, 8'h00, 1'b1);
            run_case(t, 4'h1, 8'hFF, 8'hFF, 8'hFF, 8'h04, 8'h00, 1'b1);
            run_case(t, 4'h2, 8'hFF, 8'h80, 8'hFF, 8'h84, 8'h80, 1'b1);
            run_case(t, 4'h1, 8'h10, 8'h00, 8'hFF, 8'h15, 8'h00, 1'b0);
        end
        chk({24'h0, ticks}, 32'h00000003);
        $display("test timer modes done");
        wr(IDX_MODE, 8'h0D);
        wr(IDX_TL0, 8'h00);
        glvl[0] <= 1'b0;
        wr(IDX_CONTROL, 8'h10);
        repeat (2) pulse(0);
        glvl[0] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        repeat (3) pulse(0);
        wr(IDX_CONTROL, 8'h00);
        rd_chk(IDX_TL0, 8'h03, 8'hFF);
        $display("test counter and gate done");
        for (int t = 0; t < 2; t++)
        begin
            wr(IDX_CONTROL, 8'h00);
            glvl[t] <= 1'b0;
            wait_flag(t, 1'b1, s);
            chk(s, 1'b1);
            glvl[t] <= 1'b1;
            wait_flag(t, 1'b0, s);
            chk(s, 1'b0);
            wr(IDX_CONTROL, 8'h01 << (2 * t));
            glvl[t] <= 1'b0;
            wait_flag(t, 1'b1, s);
            glvl[t] <= 1'b1;
            repeat (3) @(posedge ref_clk);
            wait_flag(t, 1'b1, s);
            chk(s, 1'b1);
            ack_edge[t] <= 1'b1;
            @(posedge ref_clk);
            ack_edge[t] <= 1'b0;
            wait_flag(t, 1'b0, s);
            chk(s, 1'b0);
        end
        $display("test external irq done");
        wr(IDX_MODE, 8'h33);
        wr(IDX_TL0, 8'h00);
        wr(IDX_TL1, 8'h55);
        wr(IDX_TH0, 8'hFE);
        wr(IDX_CONTROL, 8'h40);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(overflow_flag_1, 1'b1);
        @(posedge ref_clk);
        wr(IDX_CONTROL, 8'h80);
        rd_chk(IDX_TH0, 8'h04, 8'hFF);
        rd_chk(IDX_TL0, 8'h00, 8'hFF);
        rd_chk(IDX_TL1, 8'h55, 8'hFF);
        wr(IDX_MODE, 8'h13);
        wr(IDX_CONTROL, 8'h40);
        repeat (2) @(posedge ref_clk);
        wr(IDX_CONTROL, 8'h00);
        rd_chk(IDX_TL1, 8'h59, 8'hFF);
        $display("test split mode done");
        finish_test();
    end
endmodule
